// ==== cic_top.sv ====
// core interrupt control: enables, sticky flags and the request to the core
// assumes a classic wishbone master on sys_clk and asynchronous port-b pins
`timescale 1ns/10ps

// Functional notes
// - global enable clear blocks every request; set passes each enabled source
// - peripheral-group enable clear blocks all peripheral requests
// - timer-overflow enable gates the timer-overflow flag into the request
// - external edge sets the pin-edge flag; software clears it
// - any change on the upper four port-b pins sets the change flag
// - reading port-b data clears the change flag
// - flags set regardless of their own enable or the global enable
module cic_top
  import cic_pkg::*;
#(
  parameter int INSTR_DIV = CIC_INSTR_DIV,
  parameter bit EDGE_RISING = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] port_b_pins,
  input wire logic periph_irq,
  output logic irq_to_core,
  output logic instr_tick
);

  initial
  begin
    if (INSTR_DIV < 1 || INSTR_DIV > 255)
      $error("cic_top: INSTR_DIV must lie in 1..255");
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
    reg_hit = (adr[1:0] == 2'h0) && (adr[7:2] == idx);
  endfunction : reg_hit

  function automatic logic [7:0] merge_bit(input logic [7:0] val, input int pos,
                                           input logic b);
    logic [7:0] t;
    t = val;
    t[pos] = b;
    merge_bit = t;
  endfunction : merge_bit

  ////////////////////////////////////////////////////////////////////////////
  // instruction-cycle divider

  logic [7:0] div_cnt_r;
  logic tick;

  assign tick = (div_cnt_r == 8'(INSTR_DIV - 1));
  assign instr_tick = tick;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      div_cnt_r <= 8'h00;
    else if (tick)
      div_cnt_r <= 8'h00;
    else
      div_cnt_r <= div_cnt_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sensing

  logic [7:0] pins_sync;
  logic upper_change;
  logic edge_event;

  cic_port_sense #(
    .WIDTH(8),
    .EDGE_RISING(EDGE_RISING)
  ) cic_port_sense_i (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pins_async(port_b_pins),
    .pins_sync(pins_sync),
    .upper_change(upper_change),
    .edge_event(edge_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, side effects at ack edge

  logic ack_r;
  logic [31:0] rdat_r;
  logic req;
  logic commit;
  logic wr_commit;
  logic rd_commit;
  logic lane0;
  logic [7:0] timer_r;
  logic [7:0] intctl_r;

  assign req = wb_cyc_i & wb_stb_i;
  assign commit = req & ack_r;
  assign lane0 = wb_sel_i[0];
  assign wr_commit = commit & wb_we_i & lane0;
  assign rd_commit = commit & ~wb_we_i;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  // unmapped addresses still answer, with zero data
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rdat_r <= 32'h0000_0000;
    else if (req & ~ack_r & ~wb_we_i)
    begin
      if (reg_hit(wb_adr_i, CIC_IDX_INTCTL))
        rdat_r <= {24'h00_0000, intctl_r};
      else if (reg_hit(wb_adr_i, CIC_IDX_TIMER))
        rdat_r <= {24'h00_0000, timer_r};
      else if (reg_hit(wb_adr_i, CIC_IDX_PORT_B))
        rdat_r <= {24'h00_0000, pins_sync};
      else
        rdat_r <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // eight-bit timer, counts instruction cycles

  logic timer_wr;
  logic timer_ovf;

  assign timer_wr = wr_commit & reg_hit(wb_adr_i, CIC_IDX_TIMER);
  assign timer_ovf = tick & ~timer_wr & (timer_r == CIC_TIMER_MAX);

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      timer_r <= CIC_TIMER_RESET;
    else if (timer_wr)
      timer_r <= wb_dat_i[7:0];
    else if (tick)
      timer_r <= timer_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt_control register; hardware sets win over any clear

  logic intctl_wr;
  logic port_read;
  logic [7:0] intctl_nxt;

  assign intctl_wr = wr_commit & reg_hit(wb_adr_i, CIC_IDX_INTCTL);
  assign port_read = rd_commit & reg_hit(wb_adr_i, CIC_IDX_PORT_B);

  always_comb
  begin
    intctl_nxt = intctl_r;
    if (intctl_wr)
      intctl_nxt = wb_dat_i[7:0];
    if (port_read)
      intctl_nxt = merge_bit(intctl_nxt, CIC_BIT_CHANGE_FLAG, 1'b0);
    // sets take no notice of any enable bit
    if (timer_ovf)
      intctl_nxt = merge_bit(intctl_nxt, CIC_BIT_TOVF_FLAG, 1'b1);
    if (edge_event)
      intctl_nxt = merge_bit(intctl_nxt, CIC_BIT_EDGE_FLAG, 1'b1);
    if (upper_change)
      intctl_nxt = merge_bit(intctl_nxt, CIC_BIT_CHANGE_FLAG, 1'b1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      intctl_r <= CIC_INTCTL_RESET;
    else
      intctl_r <= intctl_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // request to the core

  logic src_tovf;
  logic src_edge;
  logic src_change;
  logic src_periph;

  assign src_tovf = intctl_r[CIC_BIT_TOVF_EN] & intctl_r[CIC_BIT_TOVF_FLAG];
  assign src_edge = intctl_r[CIC_BIT_EDGE_EN] & intctl_r[CIC_BIT_EDGE_FLAG];
  assign src_change = intctl_r[CIC_BIT_CHANGE_EN] & intctl_r[CIC_BIT_CHANGE_FLAG];
  assign src_periph = intctl_r[CIC_BIT_PERIPH_EN] & periph_irq;

  // registered so the core sees a glitch-free level
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      irq_to_core <= 1'b0;
    else
      irq_to_core <= intctl_r[CIC_BIT_GLOBAL_EN]
                     & (src_tovf | src_edge | src_change | src_periph);
  end

endmodule : cic_top

// ==== cic_pkg.sv ====
// constants shared by the core interrupt control block
// assumes one 40 MHz clock and a 32-bit classic wishbone register port
package cic_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] CIC_IDX_TIMER = 6'h01;
  localparam logic [5:0] CIC_IDX_PORT_B = 6'h06;
  localparam logic [5:0] CIC_IDX_INTCTL = 6'h0b;

  // interrupt_control field positions
  localparam int CIC_BIT_GLOBAL_EN = 7;
  localparam int CIC_BIT_PERIPH_EN = 6;
  localparam int CIC_BIT_TOVF_EN = 5;
  localparam int CIC_BIT_EDGE_EN = 4;
  localparam int CIC_BIT_CHANGE_EN = 3;
  localparam int CIC_BIT_TOVF_FLAG = 2;
  localparam int CIC_BIT_EDGE_FLAG = 1;
  localparam int CIC_BIT_CHANGE_FLAG = 0;

  // values after reset, and the timer count that overflows on the next tick
  localparam logic [7:0] CIC_INTCTL_RESET = 8'h00;
  localparam logic [7:0] CIC_TIMER_RESET = 8'h00;
  localparam logic [7:0] CIC_TIMER_MAX = 8'hff;

  // system clock cycles per instruction cycle
  localparam int CIC_INSTR_DIV = 4;

  // clocks after reset before the pin history is trusted for edge detection
  localparam logic [1:0] CIC_SYNC_WARM = 2'h3;

  // port-b pin layout
  localparam int CIC_EDGE_PIN = 0;
  localparam int CIC_UPPER_LO = 4;
  localparam int CIC_UPPER_HI = 7;

endpackage : cic_pkg

// ==== cic_port_sense.sv ====
// port-b pin synchroniser with change and edge detection
// assumes asynchronous pins and the single system clock
`timescale 1ns/10ps
module cic_port_sense
  import cic_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter bit EDGE_RISING = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pins_async,
  output logic [WIDTH-1:0] pins_sync,
  output logic upper_change,
  output logic edge_event
);

  initial
  begin
    if (WIDTH <= CIC_UPPER_HI)
      $error("cic_port_sense: WIDTH must cover the upper port pins");
  end

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;
  logic [1:0] warm_r;
  logic live;

  // a pin already high at release would look like an edge against the
  // cleared history, so detection waits until the history holds real levels
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      warm_r <= 2'h0;
    else if (warm_r != CIC_SYNC_WARM)
      warm_r <= warm_r + 2'h1;
  end

  assign live = (warm_r == CIC_SYNC_WARM);

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= pins_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign pins_sync = sync_r;
  // any level change on the four upper pins
  assign upper_change = live
                        & (sync_r[CIC_UPPER_HI:CIC_UPPER_LO] != prev_r[CIC_UPPER_HI:CIC_UPPER_LO]);
  assign edge_event = live & (EDGE_RISING ? (sync_r[CIC_EDGE_PIN] & ~prev_r[CIC_EDGE_PIN])
                                          : (~sync_r[CIC_EDGE_PIN] & prev_r[CIC_EDGE_PIN]));

endmodule : cic_port_sense

// ==== cic_top_props.sv ====
// port checker for cic_top
// assumes binding to cic_top and a bench that always writes with sel of 4'hf
`timescale 1ns/10ps
module cic_top_props #(parameter int INSTR_DIV = 4)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic periph_irq,
  input wire logic irq_to_core,
  input wire logic instr_tick
);
  logic [4:0] en_r;
  logic [7:0] up_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // enables change only by bus writes, so the port view can mirror them
  always_ff @(posedge sys_clk)
    if (!nrst) en_r <= 5'h00;
    else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h2c) en_r <= wb_dat_i[7:3];
  always_ff @(posedge sys_clk)
    if (!nrst) up_r <= 8'h00;
    else if (up_r != 8'hff) up_r <= up_r + 8'h01;
  ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
  glob_off_a: assert property (!en_r[4] |=> !irq_to_core) else $error("irq while off");
  periph_pass_a: assert property (en_r[4:3] == 2'h3 && periph_irq |=> irq_to_core)
    else $error("peripheral request lost");
  all_masked_a: assert property (en_r == 5'h10 |=> !irq_to_core)
    else $error("masked irq");
  tick_gap_a: assert property (instr_tick && up_r > INSTR_DIV |-> $past(instr_tick, INSTR_DIV))
    else $error("tick spacing");
endmodule : cic_top_props
bind cic_top cic_top_props #(.INSTR_DIV(INSTR_DIV)) cic_top_props_i (.sys_clk(sys_clk),
  .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periph_irq(periph_irq),
  .irq_to_core(irq_to_core), .instr_tick(instr_tick));

// ==== cic_core_model.sv ====
// core interrupt entry model: counts each new request
// assumes irq_to_core is a level on sys_clk
`timescale 1ns/10ps
module cic_core_model
(
  input wire logic sys_clk,
  input wire logic irq_to_core,
  output int entries
);
  logic last_r = 1'b0;
  initial entries = 0;
  // a held level is one entry; the core re-enters only after it drops
  always @(posedge sys_clk)
  begin
    if (irq_to_core && !last_r) entries <= entries + 1;
    last_r <= irq_to_core;
  end
endmodule : cic_core_model

// ==== cic_top_tb.sv ====
// self-checking bench for cic_top
// assumes the default divider of four and the package register map
`timescale 1ns/10ps
module cic_top_tb
  import cic_pkg::*;
;
  logic sys_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, pirq = 1'b0;
  logic [7:0] adr = 8'h00, pins = 8'h00, rd_q = 8'h00;
  logic [31:0] dat = 32'h0, rdat;
  logic ack, irq, tick;
  int n_mismatch = 0, comparisons = 0, entries;
  localparam logic [7:0] A_TMR = {CIC_IDX_TIMER, 2'b00};
  localparam logic [7:0] A_PB = {CIC_IDX_PORT_B, 2'b00};
  localparam logic [7:0] A_IC = {CIC_IDX_INTCTL, 2'b00};
  always #12.5 sys_clk = ~sys_clk;
  cic_top cic_top_i (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port_b_pins(pins), .periph_irq(pirq), .irq_to_core(irq),
    .instr_tick(tick));
  cic_core_model cic_core_model_i (.sys_clk(sys_clk), .irq_to_core(irq), .entries(entries));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : step
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge sys_clk); while (ack !== 1'b1);
    rd_q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd_q, exp);
  endtask : rdc
  task automatic irqc(input logic [7:0] ic, input logic exp);
    bus(1'b1, A_IC, ic);
    step(2);
    chk({7'h0, irq}, {7'h0, exp});
  endtask : irqc
  task automatic t_regs;
    rdc(A_IC, CIC_INTCTL_RESET);
    bus(1'b1, 8'h30, 8'hff);
    rdc(8'h30, 8'h00);
    $display("done regs");
  endtask : t_regs
  task automatic t_pins;
    pins <= 8'h01;
    step(5);
    rdc(A_IC, 8'h02);
    bus(1'b1, A_IC, 8'h00);
    rdc(A_IC, 8'h00);
    pins <= 8'h11;
    step(5);
    rdc(A_IC, 8'h01);
    rdc(A_PB, 8'h11);
    rdc(A_IC, 8'h00);
    $display("done pins");
  endtask : t_pins
  task automatic t_timer;
    bus(1'b1, A_TMR, CIC_TIMER_MAX);
    step(20);
    rdc(A_IC, 8'h04);
    chk({7'h0, irq}, 8'h00);
    irqc(8'ha4, 1'b1);
    irqc(8'h00, 1'b0);
    $display("done timer");
  endtask : t_timer
  task automatic t_irq;
    irqc(8'h12, 1'b0);
    irqc(8'h92, 1'b1);
    irqc(8'h89, 1'b1);
    pirq <= 1'b1;
    irqc(8'h80, 1'b0);
    irqc(8'hc0, 1'b1);
    pirq <= 1'b0;
    irqc(8'h00, 1'b0);
    chk(8'(entries), 8'h03);
    $display("done irq");
  endtask : t_irq
  task automatic t_reset;
    bus(1'b1, A_IC, 8'hff);
    step(2);
    chk({7'h0, irq}, 8'h01);
    nrst <= 1'b0;
    step(3);
    nrst <= 1'b1;
    step(1);
    chk({7'h0, irq}, 8'h00);
    step(4);
    rdc(A_IC, CIC_INTCTL_RESET);
    $display("done reset");
  endtask : t_reset
  task automatic close_out;
    $display("compared %0d mismatched %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  initial
  begin
    #20000;
    n_mismatch++;
    close_out;
  end
  initial
  begin
    step(5);
    nrst <= 1'b1;
    step(1);
    t_regs;
    t_pins;
    t_timer;
    t_irq;
    t_reset;
    close_out;
  end
endmodule : cic_top_tb
